//--- logic/snoop_pkg.sv
/*
  shared constants for the cache snoop controller and its far end.
  assumes one system clock drives both ends.
*/
`default_nettype none

package snoop_pkg;

  // ----------------------------------------
  // address and cache line
  // ----------------------------------------
  localparam int ADDR_W = 32;
  localparam logic [31:0] MEM_REGION_BASE = 32'h0000_0000;
  localparam logic [31:0] MEM_REGION_TOP = 32'h07ff_ffff;
  localparam int LINE_BYTES = 16;
  localparam logic [1:0] FIRST_BEAT = 2'h0;
  localparam logic [1:0] LAST_BEAT = 2'h3;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  // cycles after the strobe in which a modified hit may still show up
  localparam logic [1:0] MODIFIED_HIT_N_WINDOW = 2'h2;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic ACTIVE_LOW_IDLE = 1'b1;
  localparam logic ACTIVE_HIGH_IDLE = 1'b0;

endpackage

`default_nettype wire

//--- logic/snoop_if.sv
/*
  wires between the snoop controller and the cpu plus bus masters.
  assumes both ends run on the same clock; no clocking block here.
*/
`timescale 1ns/1ps
`default_nettype none

interface snoop_if;
  import snoop_pkg::*;

  // ----------------------------------------
  // cpu hold and snoop
  // ----------------------------------------
  logic hold_req;
  logic hold_ack;
  logic cpu_address_hold;
  logic external_snoop_strobe_n;
  logic modified_hit_n;
  logic castout_valid;
  logic [1:0] castout_offset;

  // ----------------------------------------
  // local bus master
  // ----------------------------------------
  logic local_req;
  logic local_master_grant_n;
  logic local_ads_n;
  logic local_rdy_n;
  logic local_writeback_abort_n;

  // ----------------------------------------
  // isa master or dma
  // ----------------------------------------
  logic isa_req;
  logic isa_addr_valid;
  logic isa_finish;
  logic [ADDR_W-1:0] master_addr;

  modport dev (
    output hold_req, cpu_address_hold, external_snoop_strobe_n,
    output local_master_grant_n, local_rdy_n, local_writeback_abort_n, isa_finish,
    input hold_ack, modified_hit_n, castout_valid, castout_offset,
    input local_req, local_ads_n, isa_req, isa_addr_valid, master_addr
  );

  modport far (
    input hold_req, cpu_address_hold, external_snoop_strobe_n,
    input local_master_grant_n, local_rdy_n, local_writeback_abort_n, isa_finish,
    output hold_ack, modified_hit_n, castout_valid, castout_offset,
    output local_req, local_ads_n, isa_req, isa_addr_valid, master_addr
  );

endinterface

`default_nettype wire

//--- logic/snoop_ctrl.sv
/*
  snoop controller: runs cache inquiries for local and isa/dma masters.
  assumes cpu and masters sit on the same system clock as this block.
*/
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - snoop every master access to system memory
// - cpu flags modified hit and writes back
// - cpu yields bus; master strobes after grant
// - snoop strobe one clock after address strobe
// - no modified hit: finish from memory
// - modified hit aborts master, expect castout
// - on hit drop hold, give ready
// - isa/dma start: request hold, await acknowledge
// - after acknowledge raise cpu address hold
// - master drives address, then strobe snoop
// - castout starts at offset zero, whole line
// - cpu drops hit, reacknowledges, master finishes

module snoop_ctrl
  import snoop_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // link to cpu and masters
  snoop_if.dev bus,
  // status to the system
  output logic snoop_busy,
  output logic modified_hit_seen
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef enum logic [3:0] {
    s_idle, s_l_hold, s_l_ads, s_l_snoop, s_l_cast, s_l_end,
    s_i_hold, s_i_addr, s_i_snoop, s_i_cast, s_i_end
  } state_t;

  state_t state, next_state;
  logic [1:0] wait_cnt, next_wait_cnt;
  logic hold_req, next_hold_req;
  logic addr_hold, next_addr_hold;
  logic strobe_n, next_strobe_n;
  logic grant_n, next_grant_n;
  logic rdy_n, next_rdy_n;
  logic abort_n, next_abort_n;
  logic finish, next_finish;
  logic busy, next_busy;
  logic hit_seen, next_hit_seen;
  logic in_mem;

  assign in_mem = (bus.master_addr >= MEM_REGION_BASE) && (bus.master_addr <= MEM_REGION_TOP);

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    next_state = state;
    next_wait_cnt = wait_cnt;
    next_hold_req = hold_req;
    next_addr_hold = addr_hold;
    next_strobe_n = ACTIVE_LOW_IDLE;
    next_grant_n = grant_n;
    next_rdy_n = ACTIVE_LOW_IDLE;
    next_abort_n = ACTIVE_LOW_IDLE;
    next_finish = ACTIVE_HIGH_IDLE;
    next_hit_seen = ACTIVE_HIGH_IDLE;
    next_busy = (state != s_idle);
    case (state)
      s_idle: begin
        // local masters win a tie; isa cycles are slow anyway
        if (bus.local_req) begin
          next_hold_req = 1'b1;
          next_state = s_l_hold;
        end else if (bus.isa_req) begin
          next_hold_req = 1'b1;
          next_state = s_i_hold;
        end
      end
      s_l_hold: begin
        // grant only once the cpu has let go
        if (bus.hold_ack) begin
          next_grant_n = 1'b0;
          next_state = s_l_ads;
        end
      end
      s_l_ads: begin
        if (!bus.local_ads_n) begin
          next_wait_cnt = 2'h0;
          if (in_mem) begin
            // single clock strobe after address strobe
            next_strobe_n = 1'b0;
            next_state = s_l_snoop;
          end else begin
            next_rdy_n = 1'b0;
            next_hold_req = 1'b0;
            next_grant_n = 1'b1;
            next_state = s_l_end;
          end
        end
      end
      s_l_snoop: begin
        next_wait_cnt = wait_cnt + 2'h1;
        if (!bus.modified_hit_n) begin
          // abort the master cycle on a dirty line
          next_abort_n = 1'b0;
          next_hit_seen = 1'b1;
          // release hold and end the local cycle
          next_hold_req = 1'b0;
          next_rdy_n = 1'b0;
          next_grant_n = 1'b1;
          next_state = s_l_cast;
        end else if (wait_cnt == MODIFIED_HIT_N_WINDOW) begin
          // clean line, memory completes the cycle
          next_rdy_n = 1'b0;
          next_hold_req = 1'b0;
          next_grant_n = 1'b1;
          next_state = s_l_end;
        end
      end
      s_l_cast: begin
        // abort follows the hit line during the castout
        next_abort_n = bus.modified_hit_n;
        if (bus.modified_hit_n) begin
          next_state = s_l_end;
        end
      end
      s_l_end: begin
        if (!bus.local_req) begin
          next_state = s_idle;
        end
      end
      s_i_hold: begin
        if (bus.hold_ack) begin
          next_addr_hold = 1'b1;
          next_state = s_i_addr;
        end
      end
      s_i_addr: begin
        // snoop once the master address is on the bus
        if (bus.isa_addr_valid) begin
          next_wait_cnt = 2'h0;
          if (in_mem) begin
            next_strobe_n = 1'b0;
            next_state = s_i_snoop;
          end else begin
            next_finish = 1'b1;
            next_state = s_i_end;
          end
        end
      end
      s_i_snoop: begin
        next_wait_cnt = wait_cnt + 2'h1;
        if (!bus.modified_hit_n) begin
          // the cpu needs its address bus back to cast out
          next_addr_hold = 1'b0;
          next_hit_seen = 1'b1;
          next_state = s_i_cast;
        end else if (wait_cnt == MODIFIED_HIT_N_WINDOW) begin
          next_finish = 1'b1;
          next_state = s_i_end;
        end
      end
      s_i_cast: begin
        // wait for hit negated and acknowledge again
        if (bus.modified_hit_n && bus.hold_ack) begin
          next_finish = 1'b1;
          next_state = s_i_end;
        end
      end
      s_i_end: begin
        if (!bus.isa_req) begin
          next_hold_req = 1'b0;
          next_addr_hold = 1'b0;
          next_state = s_idle;
        end
      end
      default: begin
        next_state = s_idle;
      end
    endcase
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  // every output from a flop, idle on reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= s_idle;
      wait_cnt <= 2'h0;
      hold_req <= ACTIVE_HIGH_IDLE;
      addr_hold <= ACTIVE_HIGH_IDLE;
      strobe_n <= ACTIVE_LOW_IDLE;
      grant_n <= ACTIVE_LOW_IDLE;
      rdy_n <= ACTIVE_LOW_IDLE;
      abort_n <= ACTIVE_LOW_IDLE;
      finish <= ACTIVE_HIGH_IDLE;
      busy <= ACTIVE_HIGH_IDLE;
      hit_seen <= ACTIVE_HIGH_IDLE;
    end else begin
      state <= next_state;
      wait_cnt <= next_wait_cnt;
      hold_req <= next_hold_req;
      addr_hold <= next_addr_hold;
      strobe_n <= next_strobe_n;
      grant_n <= next_grant_n;
      rdy_n <= next_rdy_n;
      abort_n <= next_abort_n;
      finish <= next_finish;
      busy <= next_busy;
      hit_seen <= next_hit_seen;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign bus.hold_req = hold_req;
  assign bus.cpu_address_hold = addr_hold;
  assign bus.external_snoop_strobe_n = strobe_n;
  assign bus.local_master_grant_n = grant_n;
  assign bus.local_rdy_n = rdy_n;
  assign bus.local_writeback_abort_n = abort_n;
  assign bus.isa_finish = finish;
  assign snoop_busy = busy;
  assign modified_hit_seen = hit_seen;

endmodule // snoop_ctrl

`default_nettype wire

//--- logic/snoop_far_end.sv
/*
  far end of the snoop link: cpu with a write-back cache, one local
  master and one isa/dma master, all under user control.
  assumes the snoop controller shares the system clock.
*/
`timescale 1ns/1ps
`default_nettype none

module snoop_far_end
  import snoop_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // link to the snoop controller
  snoop_if.far bus,
  // user control
  input wire logic local_start,
  input wire logic isa_start,
  input wire logic [ADDR_W-1:0] start_addr,
  input wire logic line_dirty,
  // user status
  output logic master_busy,
  output logic master_done,
  output logic master_aborted
);

  // ----------------------------------------
  // cpu side
  // ----------------------------------------
  typedef enum logic [1:0] {c_idle, c_hit, c_cast} cpu_state_t;
  cpu_state_t cstate, next_cstate;
  logic hold_ack, next_hold_ack;
  logic modified_hit_n_n, next_modified_hit_n_n;
  logic cast_valid, next_cast_valid;
  logic [1:0] beat, next_beat;
  logic snoop_under_cpu_address_hold, next_snoop_under_cpu_address_hold;

  always_comb begin
    next_cstate = cstate;
    next_modified_hit_n_n = modified_hit_n_n;
    next_beat = beat;
    next_snoop_under_cpu_address_hold = snoop_under_cpu_address_hold;
    next_cast_valid = 1'b0;
    case (cstate)
      c_idle: begin
        // flag a dirty line on the snoop
        if (!bus.external_snoop_strobe_n && line_dirty) begin
          next_modified_hit_n_n = 1'b0;
          next_snoop_under_cpu_address_hold = bus.cpu_address_hold;
          next_cstate = c_hit;
        end
      end
      c_hit: begin
        // castout waits for the bus, then offset zero first
        // local snoop waits for hold to drop, isa snoop only for the address bus
        if (snoop_under_cpu_address_hold ? !bus.cpu_address_hold : !bus.hold_req) begin
          next_beat = FIRST_BEAT;
          next_cast_valid = 1'b1;
          next_cstate = c_cast;
        end
      end
      c_cast: begin
        if (beat == LAST_BEAT) begin
          // negate the hit after the last beat
          next_modified_hit_n_n = 1'b1;
          next_cstate = c_idle;
        end else begin
          next_beat = beat + 2'h1;
          next_cast_valid = 1'b1;
        end
      end
      default: begin
        next_cstate = c_idle;
      end
    endcase
    // acknowledge hold only while not busy with a castout
    next_hold_ack = bus.hold_req && (next_cstate == c_idle);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cstate <= c_idle;
      hold_ack <= ACTIVE_HIGH_IDLE;
      modified_hit_n_n <= ACTIVE_LOW_IDLE;
      cast_valid <= ACTIVE_HIGH_IDLE;
      beat <= FIRST_BEAT;
      snoop_under_cpu_address_hold <= ACTIVE_HIGH_IDLE;
    end else begin
      cstate <= next_cstate;
      hold_ack <= next_hold_ack;
      modified_hit_n_n <= next_modified_hit_n_n;
      cast_valid <= next_cast_valid;
      beat <= next_beat;
      snoop_under_cpu_address_hold <= next_snoop_under_cpu_address_hold;
    end
  end

  // ----------------------------------------
  // masters
  // ----------------------------------------
  typedef enum logic [2:0] {m_idle, m_l_req, m_l_wait, m_i_req, m_i_wait, m_i_end} master_state_t;
  master_state_t mstate, next_mstate;
  logic lreq, next_lreq;
  logic ads_n, next_ads_n;
  logic ireq, next_ireq;
  logic avalid, next_avalid;
  logic [ADDR_W-1:0] addr, next_addr;
  logic done, next_done;
  logic aborted, next_aborted;
  logic mbusy, next_mbusy;

  always_comb begin
    next_mstate = mstate;
    next_lreq = lreq;
    next_ireq = ireq;
    next_avalid = avalid;
    next_addr = addr;
    next_ads_n = 1'b1;
    next_done = 1'b0;
    next_aborted = 1'b0;
    case (mstate)
      m_idle: begin
        if (local_start) begin
          next_lreq = 1'b1;
          next_addr = start_addr;
          next_mstate = m_l_req;
        end else if (isa_start) begin
          next_ireq = 1'b1;
          next_addr = start_addr;
          next_mstate = m_i_req;
        end
      end
      m_l_req: begin
        // address strobe once the grant is seen
        if (!bus.local_master_grant_n) begin
          next_ads_n = 1'b0;
          next_mstate = m_l_wait;
        end
      end
      m_l_wait: begin
        if (!bus.local_rdy_n) begin
          next_lreq = 1'b0;
          next_done = 1'b1;
          next_aborted = !bus.local_writeback_abort_n;
          next_mstate = m_idle;
        end
      end
      m_i_req: begin
        // mark the address valid once the cpu address hold is seen
        if (bus.cpu_address_hold) begin
          next_avalid = 1'b1;
          next_mstate = m_i_wait;
        end
      end
      m_i_wait: begin
        // finish only when the controller allows it
        if (bus.isa_finish) begin
          next_avalid = 1'b0;
          next_ireq = 1'b0;
          next_done = 1'b1;
          next_mstate = m_i_end;
        end
      end
      m_i_end: begin
        // lets the controller leave its end state before a new start
        next_mstate = m_idle;
      end
      default: begin
        next_mstate = m_idle;
      end
    endcase
    // busy from a flop, same timing as the request flops
    next_mbusy = next_lreq | next_ireq;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mstate <= m_idle;
      lreq <= ACTIVE_HIGH_IDLE;
      ads_n <= ACTIVE_LOW_IDLE;
      ireq <= ACTIVE_HIGH_IDLE;
      avalid <= ACTIVE_HIGH_IDLE;
      addr <= 32'h0000_0000;
      done <= ACTIVE_HIGH_IDLE;
      aborted <= ACTIVE_HIGH_IDLE;
      mbusy <= ACTIVE_HIGH_IDLE;
    end else begin
      mstate <= next_mstate;
      lreq <= next_lreq;
      ads_n <= next_ads_n;
      ireq <= next_ireq;
      avalid <= next_avalid;
      addr <= next_addr;
      done <= next_done;
      aborted <= next_aborted;
      mbusy <= next_mbusy;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign bus.hold_ack = hold_ack;
  assign bus.modified_hit_n = modified_hit_n_n;
  assign bus.castout_valid = cast_valid;
  assign bus.castout_offset = beat;
  assign bus.local_req = lreq;
  assign bus.local_ads_n = ads_n;
  assign bus.isa_req = ireq;
  assign bus.isa_addr_valid = avalid;
  assign bus.master_addr = addr;
  assign master_busy = mbusy;
  assign master_done = done;
  assign master_aborted = aborted;

endmodule // snoop_far_end

`default_nettype wire

//--- dv/snoop_checker.sv
/*
  assertions on the snoop link between controller and far end.
  assumes one clock, rst async active high, inputs taken from the interface.
*/
`timescale 1ns/1ps
`default_nettype none

module snoop_checker
  import snoop_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // cpu hold and snoop
  input wire logic hold_req,
  input wire logic hold_ack,
  input wire logic cpu_address_hold,
  input wire logic external_snoop_strobe_n,
  input wire logic modified_hit_n,
  // local master
  input wire logic local_req,
  input wire logic local_master_grant_n,
  input wire logic local_ads_n,
  input wire logic local_rdy_n,
  input wire logic local_writeback_abort_n,
  // isa master or dma
  input wire logic isa_req,
  input wire logic isa_addr_valid,
  input wire logic isa_finish,
  input wire logic [ADDR_W-1:0] master_addr
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // ----------------------------------------
  // sequences
  // ----------------------------------------
  sequence s_isa_granted;
    $rose(isa_req) && !local_req ##1 hold_req ##1 hold_ack;
  endsequence

  // a hit may still show two cycles after the strobe, so wait both out
  sequence s_clean_wait;
    $fell(external_snoop_strobe_n) && !local_master_grant_n ##1 modified_hit_n [*2];
  endsequence

  // ----------------------------------------
  // properties
  // ----------------------------------------
  // local access snooped
  a_local_snooped: assert property ($fell(local_ads_n) && master_addr <= MEM_REGION_TOP |=>
    !external_snoop_strobe_n) else $error("no snoop strobe after local address strobe");
  a_strobe_single: assert property ($fell(external_snoop_strobe_n) |=> external_snoop_strobe_n)
    else $error("snoop strobe longer than one clock");
  a_strobe_source: assert property ($fell(external_snoop_strobe_n) |->
    !$past(local_ads_n) || $past(isa_addr_valid)) else $error("snoop strobe without a master address");
  a_clean_ready: assert property (s_clean_wait |=> !local_rdy_n && local_writeback_abort_n)
    else $error("clean local cycle not ended in time");
  a_hit_aborts: assert property (!local_master_grant_n && $fell(modified_hit_n) |=>
    !local_writeback_abort_n && !local_rdy_n && !hold_req) else $error("modified hit not aborted");
  a_ready_single: assert property ($fell(local_rdy_n) |=> local_rdy_n)
    else $error("ready longer than one clock");
  a_req_hold: assert property ($rose(local_req) || $rose(isa_req) |=> hold_req)
    else $error("hold request missing after master request");
  a_cpu_address_hold_after_ack: assert property (s_isa_granted |=> cpu_address_hold)
    else $error("address hold missing after acknowledge");
  a_isa_snooped: assert property (cpu_address_hold && $rose(isa_addr_valid) &&
    master_addr <= MEM_REGION_TOP |=> !external_snoop_strobe_n) else $error("isa address not snooped");
  a_cpu_address_hold_release: assert property (cpu_address_hold && $fell(modified_hit_n) |=> !cpu_address_hold)
    else $error("address hold kept during castout");
  a_finish_gated: assert property (isa_finish |-> modified_hit_n && hold_ack ##1 !isa_finish)
    else $error("isa finish before cpu released");
endmodule // snoop_checker

`default_nettype wire

//--- dv/l1_snoop_writeback_control_tb.sv
/*
  self-checking bench: controller and far end joined by the interface.
  assumes one 20 mhz clock, rst async active high, far end under bench control.
*/
`timescale 1ns/1ps
`default_nettype none

module l1_snoop_writeback_control_tb
  import snoop_pkg::*;
;
  logic clk, rst, local_start, isa_start, line_dirty;
  logic [ADDR_W-1:0] start_addr;
  logic snoop_busy, modified_hit_seen, master_busy, master_done, master_aborted;
  int miscompares, check_count;
  int t_ads, t_strobe, t_rdy, n_strobe, n_beats, n_fin, n_done;
  logic bad_order, got_abort, got_hit, got_cpu_address_hold, got_busy, got_mbusy, aborted;

  // ----------------------------------------
  // design and checker
  // ----------------------------------------
  snoop_if snoop_if_i ();
  snoop_ctrl snoop_ctrl_i (.clk(clk), .rst(rst), .bus(snoop_if_i.dev), .snoop_busy(snoop_busy),
    .modified_hit_seen(modified_hit_seen));
  snoop_far_end snoop_far_end_i (.clk(clk), .rst(rst), .bus(snoop_if_i.far), .local_start(local_start),
    .isa_start(isa_start), .start_addr(start_addr), .line_dirty(line_dirty), .master_busy(master_busy),
    .master_done(master_done), .master_aborted(master_aborted));
  snoop_checker snoop_checker_i (.clk(clk), .rst(rst), .hold_req(snoop_if_i.hold_req),
    .hold_ack(snoop_if_i.hold_ack), .cpu_address_hold(snoop_if_i.cpu_address_hold),
    .external_snoop_strobe_n(snoop_if_i.external_snoop_strobe_n), .modified_hit_n(snoop_if_i.modified_hit_n),
    .local_req(snoop_if_i.local_req), .local_master_grant_n(snoop_if_i.local_master_grant_n),
    .local_ads_n(snoop_if_i.local_ads_n), .local_rdy_n(snoop_if_i.local_rdy_n),
    .local_writeback_abort_n(snoop_if_i.local_writeback_abort_n), .isa_req(snoop_if_i.isa_req),
    .isa_addr_valid(snoop_if_i.isa_addr_valid), .isa_finish(snoop_if_i.isa_finish),
    .master_addr(snoop_if_i.master_addr));

  always #25 clk = ~clk;

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check_idle;
    check({snoop_if_i.hold_req, snoop_if_i.cpu_address_hold, snoop_if_i.external_snoop_strobe_n,
      snoop_if_i.local_master_grant_n, snoop_if_i.local_rdy_n, snoop_if_i.local_writeback_abort_n,
      snoop_if_i.isa_finish, snoop_busy}, 32'h3c);
  endtask

  // one master cycle, then 30 cycles of watching the link; long enough for a castout tail
  task automatic run_cycle(input logic loc, input logic [ADDR_W-1:0] addr, input logic dirty);
    t_ads = -99;
    t_strobe = -99;
    t_rdy = -99;
    n_strobe = 0;
    n_beats = 0;
    n_fin = 0;
    n_done = 0;
    bad_order = 0;
    got_abort = 0;
    got_hit = 0;
    got_cpu_address_hold = 0;
    got_busy = 0;
    got_mbusy = 0;
    aborted = 0;
    @(posedge clk);
    start_addr <= addr;
    line_dirty <= dirty;
    local_start <= loc;
    isa_start <= !loc;
    @(posedge clk);
    local_start <= 1'b0;
    isa_start <= 1'b0;
    for (int k = 0; k < 30; k++) begin
      @(posedge clk);
      #1;
      if (snoop_if_i.local_ads_n === 1'b0) t_ads = k;
      if (snoop_if_i.local_rdy_n === 1'b0) t_rdy = k;
      if (snoop_if_i.external_snoop_strobe_n === 1'b0) begin
        n_strobe++;
        t_strobe = k;
      end
      if (snoop_if_i.castout_valid === 1'b1) begin
        if (snoop_if_i.castout_offset !== n_beats[1:0]) bad_order = 1;
        n_beats++;
      end
      if (snoop_if_i.local_writeback_abort_n === 1'b0) got_abort = 1;
      if (snoop_if_i.cpu_address_hold === 1'b1) got_cpu_address_hold = 1;
      if (snoop_if_i.isa_finish === 1'b1) n_fin++;
      if (modified_hit_seen === 1'b1) got_hit = 1;
      if (snoop_busy === 1'b1) got_busy = 1;
      if (master_busy === 1'b1) got_mbusy = 1;
      if (master_done === 1'b1) begin
        n_done++;
        aborted = master_aborted;
      end
    end
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic test_reset_idle;
    repeat (3) @(posedge clk);
    #1;
    check_idle();
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    check_idle();
  endtask

  task automatic test_local_clean;
    run_cycle(1'b1, 32'h0000_1000, 1'b0);
    check(n_strobe, 1);
    check(t_strobe - t_ads, 1);
    check(t_rdy - t_strobe, 3);
    check({got_abort, got_hit, aborted, got_busy}, 32'h1);
    check(n_done, 1);
    check({got_mbusy, master_busy}, 32'h2);
  endtask

  task automatic test_local_dirty;
    run_cycle(1'b1, 32'h0000_2040, 1'b1);
    check(t_rdy - t_strobe, 2);
    check({got_hit, got_abort, aborted}, 32'h7);
    check(n_beats, 4);
    check(bad_order, 0);
  endtask

  task automatic test_isa_clean;
    run_cycle(1'b0, 32'h0000_3000, 1'b0);
    check({got_cpu_address_hold, got_busy, got_hit}, 32'h6);
    check(n_strobe, 1);
    check(n_fin, 1);
    check(n_beats, 0);
  endtask

  task automatic test_isa_dirty;
    run_cycle(1'b0, 32'h07ff_fff0, 1'b1);
    check({got_hit, bad_order}, 32'h2);
    check(n_beats, 4);
    check(n_fin, 1);
    check(n_done, 1);
  endtask

  task automatic test_out_of_region;
    run_cycle(1'b1, 32'h0800_0000, 1'b1);
    check(n_strobe, 0);
    check(t_rdy - t_ads, 1);
    check({got_hit, n_done[1:0]}, 32'h1);
    run_cycle(1'b0, 32'h0800_0000, 1'b1);
    check(n_strobe, 0);
    check({got_cpu_address_hold, got_hit}, 32'h2);
    check({n_fin[1:0], n_done[1:0]}, 32'h5);
  endtask

  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    local_start = 1'b0;
    isa_start = 1'b0;
    line_dirty = 1'b0;
    start_addr = 32'h0;
    miscompares = 0;
    check_count = 0;
    test_reset_idle();
    test_local_clean();
    test_local_dirty();
    test_isa_clean();
    test_isa_dirty();
    test_out_of_region();
    tally_and_finish();
  end

  // six runs of about 32 cycles each; ten times that is a hang
  initial begin
    repeat (2000) @(posedge clk);
    miscompares++;
    tally_and_finish();
  end
endmodule // l1_snoop_writeback_control_tb

`default_nettype wire
